// *** src/stage_route_cfg.svh ***
// Constants for the per-stage sense input routing block.
// Assumes it is included by the package and the block by its bare name.
`ifndef STAGE_ROUTE_CFG_SVH
`define STAGE_ROUTE_CFG_SVH

// Geometry of the switch matrix and the stage table.
`define NUM_STAGES      12
`define NUM_INPUTS      14
`define INPUTS_PER_WORD 7
`define FIELD_W         2
`define ROUTE_BITS      14
`define STAGE_W         4

// Route codes held in each 2-bit field.
`define ROUTE_OPEN 2'h0
`define ROUTE_NEG  2'h1
`define ROUTE_POS  2'h2
`define ROUTE_BIAS 2'h3

// Word select of the register pair inside one stage.
`define WORD_LOW  1'h0
`define WORD_HIGH 1'h1

// Bit positions in the high word for the front-end offset disables.
`define MINUS_OFF_BIT 14
`define PLUS_OFF_BIT  15

`endif

// *** src/stage_route_pkg.sv ***
// Types shared by the per-stage sense input routing block.
// Assumes the constants header sits on the include path.
`include "stage_route_cfg.svh"

package stage_route_pkg;
  typedef logic [15:0]                 route_word_t;
  typedef logic [`FIELD_W-1:0]         route_code_t;
  typedef logic [`NUM_INPUTS-1:0]      input_mask_t;
  typedef logic [2*`NUM_INPUTS-1:0]    route_all_t;
  typedef logic [`STAGE_W-1:0]         stage_idx_t;
endpackage

// *** src/stage_input_route_config.sv ***
// Per-stage routing of fourteen sense inputs onto the converter switch matrix.
// Assumes the serial port front end delivers decoded single-cycle register
// strobes, and the sequencer presents the converting stage on active_stage.
// The host fills every field of a stage before the sequencer selects it.
//
// Overview of operation
// R01: Route code 00 leaves the sense input off both converter inputs.
// R02: Route code 01 connects the sense input to the negative converter input.
// R03: Route code 10 connects the sense input to the positive converter input.
// R04: Route code 11 ties the input to bias; host should use it unused.
// R05: Low word holds inputs 0 to 6, input 0 at bits 1:0.
// R06: High word holds inputs 7 to 13, input 7 at bits 1:0.
// R07: High word bit 14 set disables the negative front-end offset.
// R08: High word bit 15 set disables the positive front-end offset.
// R09: Twelve stages each own a register pair, applied while that stage converts.
// R10: Low word bits 15:14 are unused and never affect routing.
// R11: Route words are undefined after reset; host programs them before use.
`timescale 1ns/100ps
`include "stage_route_cfg.svh"

module stage_input_route_config
  import stage_route_pkg::*;
#(
  parameter int NUM_STAGES = `NUM_STAGES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port from the serial interface
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire stage_idx_t  reg_stage,
  input  wire logic        reg_word_sel,
  input  wire route_word_t reg_wdata,
  output logic             reg_rd_valid,
  output route_word_t      reg_rdata,
  // Stage presented by the conversion sequencer
  input  wire stage_idx_t  active_stage,
  // Switch matrix controls
  output input_mask_t      sense_to_neg,
  output input_mask_t      sense_to_pos,
  output input_mask_t      sense_to_bias,
  output logic             minus_frontend_offset_off,
  output logic             plus_frontend_offset_off
);

  // Route words. These carry no reset, so software must fill a stage first.
  logic [`ROUTE_BITS-1:0] route_low_mem  [NUM_STAGES];  // R11
  route_word_t            route_high_mem [NUM_STAGES];

  // Stage checks, the gathered fields and the output flops.
  logic        wr_stage_ok;
  logic        rd_stage_ok;
  logic        act_stage_ok;
  route_all_t  route_now;
  logic        minus_off_now;
  logic        plus_off_now;
  input_mask_t neg_nxt;
  input_mask_t pos_nxt;
  input_mask_t bias_nxt;
  input_mask_t neg_r;
  input_mask_t pos_r;
  input_mask_t bias_r;
  logic        minus_off_r;
  logic        plus_off_r;
  route_word_t rdata_r;
  logic        rd_valid_r;

  // Stage indices beyond the table are ignored rather than aliased.
  assign wr_stage_ok  = (32'(reg_stage) < NUM_STAGES);
  assign rd_stage_ok  = (32'(reg_stage) < NUM_STAGES);
  assign act_stage_ok = (32'(active_stage) < NUM_STAGES);

  // Register writes; bits 15:14 of the low word are dropped on purpose.
  // The low word stores only fourteen bits, which saves two flops per stage.
  always_ff @(posedge clk) begin
    if (reg_wr_en && wr_stage_ok) begin
      if (reg_word_sel == `WORD_LOW) begin
        route_low_mem[reg_stage] <= reg_wdata[`ROUTE_BITS-1:0];  // R05 R10
      end else begin
        route_high_mem[reg_stage] <= reg_wdata;  // R06 R07 R08
      end
    end
  end

  // Register reads answer one cycle later; unmapped stages read as zero.
  // The read data holds between reads, so a slow host may pick it up late.
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r    <= 16'h0000;
      rd_valid_r <= 1'h0;
    end else begin
      rd_valid_r <= reg_rd_en;
      if (reg_rd_en) begin
        if (!rd_stage_ok) begin
          rdata_r <= 16'h0000;
        end else if (reg_word_sel == `WORD_LOW) begin
          rdata_r <= {2'h0, route_low_mem[reg_stage]};  // R10
        end else begin
          rdata_r <= route_high_mem[reg_stage];
        end
      end
    end
  end

  // Gather the fourteen route fields of the converting stage.
  // A stage past the table yields all-open fields and both offsets applied,
  // which is the safest state for the matrix while the sequencer is idle.
  always_comb begin
    route_now     = '0;
    minus_off_now = 1'h0;
    plus_off_now  = 1'h0;
    if (act_stage_ok) begin
      route_now     = {route_high_mem[active_stage][`ROUTE_BITS-1:0],
                       route_low_mem[active_stage]};  // R09
      minus_off_now = route_high_mem[active_stage][`MINUS_OFF_BIT];  // R07
      plus_off_now  = route_high_mem[active_stage][`PLUS_OFF_BIT];  // R08
    end
  end

  // Decode each field into at most one closed switch per input.
  // Each code closes one switch at most, so no input can short two nodes.
  // An unwritten field is unknown and falls to default, leaving the input open.
  always_comb begin
    neg_nxt  = '0;
    pos_nxt  = '0;
    bias_nxt = '0;
    for (int i = 0; i < `NUM_INPUTS; i++) begin
      case (route_now[`FIELD_W*i +: `FIELD_W])
        `ROUTE_OPEN: neg_nxt[i] = 1'h0;  // R01
        `ROUTE_NEG:  neg_nxt[i] = 1'h1;  // R02
        `ROUTE_POS:  pos_nxt[i] = 1'h1;  // R03
        `ROUTE_BIAS: bias_nxt[i] = 1'h1;  // R04
        default:     neg_nxt[i] = 1'h0;
      endcase
    end
  end

  // Switch controls come from flops so the matrix never sees decode glitches.
  // Reset opens every switch, since the route words are still unknown then.
  always_ff @(posedge clk) begin
    if (rst) begin
      neg_r       <= '0;
      pos_r       <= '0;
      bias_r      <= '0;
      minus_off_r <= 1'h0;
      plus_off_r  <= 1'h0;
    end else begin
      neg_r       <= neg_nxt;
      pos_r       <= pos_nxt;
      bias_r      <= bias_nxt;
      minus_off_r <= minus_off_now;
      plus_off_r  <= plus_off_now;
    end
  end

  // Every output leaves straight from a flop.
  assign sense_to_neg              = neg_r;
  assign sense_to_pos              = pos_r;
  assign sense_to_bias             = bias_r;
  assign minus_frontend_offset_off = minus_off_r;
  assign plus_frontend_offset_off  = plus_off_r;
  assign reg_rdata                 = rdata_r;
  assign reg_rd_valid              = rd_valid_r;

  // Checks on the decoded switch controls and the register port.
  default clocking chk_cb @(posedge clk); endclocking
  default disable iff (rst);
  // Unwritten route words are unknown, so antecedents on them stay false until written.

  chk_open_route: assert property ( // R01
    act_stage_ok && route_now[1:0] == 2'h0 |=>
      !sense_to_neg[0] && !sense_to_pos[0] && !sense_to_bias[0])
    else $error("Open route code closed a switch on input 0.");

  chk_neg_route: assert property ( // R02
    act_stage_ok && route_now[1:0] == 2'h1 |=> sense_to_neg[0] && !sense_to_pos[0])
    else $error("Negative route code did not reach input 0.");

  chk_pos_route: assert property ( // R03
    act_stage_ok && route_now[27:26] == 2'h2 |=> sense_to_pos[13] && !sense_to_neg[13])
    else $error("Positive route code did not reach input 13.");

  chk_bias_route: assert property ( // R04
    act_stage_ok && route_now[15:14] == 2'h3 |=> sense_to_bias[7] && !sense_to_pos[7])
    else $error("Bias route code did not reach input 7.");

  chk_switch_exclusive: assert property ( // R01
    ((sense_to_neg & sense_to_pos) | (sense_to_neg & sense_to_bias)
     | (sense_to_pos & sense_to_bias)) == 14'h0000)
    else $error("An input is routed to two nodes at once.");

  // Offset disables follow the high word only once the stored bit is known.
  chk_minus_set: assert property ( // R07
    act_stage_ok && route_high_mem[active_stage][`MINUS_OFF_BIT] == 1'h1
      |=> minus_frontend_offset_off)
    else $error("Negative offset disable bit did not reach its output.");

  chk_minus_clear: assert property ( // R07
    act_stage_ok && route_high_mem[active_stage][`MINUS_OFF_BIT] == 1'h0
      |=> !minus_frontend_offset_off)
    else $error("Negative offset stayed disabled with its bit clear.");

  chk_plus_clear: assert property ( // R08
    act_stage_ok && route_high_mem[active_stage][`PLUS_OFF_BIT] == 1'h0
      |=> !plus_frontend_offset_off)
    else $error("Positive offset stayed disabled with its bit clear.");

  // No stage selected means both offsets stay applied.
  chk_offset_range: assert property ( // R09
    !act_stage_ok |=> !minus_frontend_offset_off && !plus_frontend_offset_off)
    else $error("A stage outside the table disabled an offset.");

  chk_plus_offset: assert property ( // R08
    act_stage_ok && route_high_mem[active_stage][15] |=> plus_frontend_offset_off)
    else $error("Positive offset disable does not follow the stage word.");

  chk_low_unused: assert property ( // R10
    reg_rd_en && reg_word_sel == 1'h0 |=> reg_rd_valid && reg_rdata[15:14] == 2'h0)
    else $error("Unused low word bits read back nonzero.");

  chk_stage_range: assert property ( // R09
    !act_stage_ok |=> sense_to_neg == 14'h0000 && sense_to_pos == 14'h0000
      && sense_to_bias == 14'h0000)
    else $error("A stage outside the table closed a switch.");

  chk_write_apply: assert property ( // R09
    reg_wr_en && wr_stage_ok && reg_word_sel == 1'h0 && reg_wdata[1:0] == 2'h1
      && active_stage == reg_stage ##1 active_stage == $past(active_stage)
      |=> sense_to_neg[0])
    else $error("A write to the converting stage did not take effect.");

  // Spot checks on fields near both ends of each word and in the middle.
  chk_pos_in1: assert property ( // R03 R05
    act_stage_ok && route_now[3:2] == 2'h2
      |=> sense_to_pos[1] && !sense_to_neg[1] && !sense_to_bias[1])
    else $error("Positive route code did not reach input 1.");

  chk_open_in3: assert property ( // R01 R05
    act_stage_ok && route_now[7:6] == 2'h0
      |=> !sense_to_pos[3] && !sense_to_neg[3] && !sense_to_bias[3])
    else $error("Open route code closed a switch on input 3.");

  chk_neg_in4: assert property ( // R02 R05
    act_stage_ok && route_now[9:8] == 2'h1
      |=> sense_to_neg[4] && !sense_to_pos[4] && !sense_to_bias[4])
    else $error("Negative route code did not reach input 4.");

  chk_bias_in6: assert property ( // R04 R05
    act_stage_ok && route_now[13:12] == 2'h3
      |=> sense_to_bias[6] && !sense_to_pos[6] && !sense_to_neg[6])
    else $error("Bias route code did not reach input 6.");

  chk_pos_in7: assert property ( // R03 R06
    act_stage_ok && route_now[15:14] == 2'h2
      |=> sense_to_pos[7] && !sense_to_neg[7] && !sense_to_bias[7])
    else $error("Positive route code did not reach input 7.");

  chk_bias_in8: assert property ( // R04 R06
    act_stage_ok && route_now[17:16] == 2'h3
      |=> sense_to_bias[8] && !sense_to_pos[8] && !sense_to_neg[8])
    else $error("Bias route code did not reach input 8.");

  chk_neg_in10: assert property ( // R02 R06
    act_stage_ok && route_now[21:20] == 2'h1
      |=> sense_to_neg[10] && !sense_to_pos[10] && !sense_to_bias[10])
    else $error("Negative route code did not reach input 10.");

  chk_pos_in11: assert property ( // R03 R06
    act_stage_ok && route_now[23:22] == 2'h2
      |=> sense_to_pos[11] && !sense_to_neg[11] && !sense_to_bias[11])
    else $error("Positive route code did not reach input 11.");

  chk_open_in13: assert property ( // R01 R06
    act_stage_ok && route_now[27:26] == 2'h0
      |=> !sense_to_pos[13] && !sense_to_neg[13] && !sense_to_bias[13])
    else $error("Open route code closed a switch on input 13.");

  chk_bias_in13: assert property ( // R04 R06
    act_stage_ok && route_now[27:26] == 2'h3
      |=> sense_to_bias[13] && !sense_to_pos[13] && !sense_to_neg[13])
    else $error("Bias route code did not reach input 13.");

  // The read port answers each strobe exactly once, one cycle later.
  chk_read_pulse: assert property ( // R05 R06
    reg_rd_en |=> reg_rd_valid)
    else $error("A read strobe got no valid answer.");

  chk_read_quiet: assert property ( // R05 R06
    !reg_rd_en |=> !reg_rd_valid)
    else $error("Read valid rose without a read strobe.");

  // Between reads the data must hold for a host that samples late.
  chk_read_hold: assert property ( // R05 R06
    !reg_rd_en |=> $stable(reg_rdata))
    else $error("Read data changed without a read strobe.");

  chk_read_unmapped: assert property ( // R09
    reg_rd_en && !rd_stage_ok |=> reg_rdata == 16'h0000)
    else $error("A stage outside the table read back nonzero.");

  // Coverage of the main scenarios.
  cov_low_write:   cover property (reg_wr_en && wr_stage_ok && reg_word_sel == 1'h0);
  cov_stage_swap:  cover property (act_stage_ok && $changed(active_stage));
  cov_bias_all:    cover property (sense_to_bias == 14'h3FFF);
  cov_offset_off:  cover property (minus_frontend_offset_off && plus_frontend_offset_off);
  cov_live_write:  cover property (reg_wr_en && wr_stage_ok && reg_stage == active_stage);

endmodule

// *** bench/sense_electrodes.sv ***
// Far-side model: the fourteen sensor electrodes on the switch matrix.
// Assumes one switch at most is closed per electrode; a clash shows as a wrong code.
`timescale 1ns/100ps

module sense_electrodes
  import stage_route_pkg::*;
(
  // Switch matrix controls
  input  wire input_mask_t to_neg,
  input  wire input_mask_t to_pos,
  input  wire input_mask_t to_bias,
  // Node each electrode sees, two bits per electrode
  output route_all_t       node_seen
);
  // A floating electrode reads 00; bias reads 11 so it equals the route code.
  always_comb begin
    for (int i = 0; i < $bits(input_mask_t); i++) begin
      node_seen[2*i +: 2] = {to_pos[i] | to_bias[i], to_neg[i] | to_bias[i]};
    end
  end
endmodule

// *** bench/stage_input_route_config_test.sv ***
// Self-checking bench for the per-stage routing block and its electrodes.
// Assumes the package and the electrode model are compiled before this file.
`timescale 1ns/100ps

module stage_input_route_config_test
  import stage_route_pkg::*;
;
  logic        clk = 0, rst = 1, reg_wr_en = 0, reg_rd_en = 0, reg_word_sel = 0;
  logic        reg_rd_valid, minus_off, plus_off;
  stage_idx_t  reg_stage = 0, active_stage = 0;
  route_word_t reg_wdata = 0, reg_rdata;
  input_mask_t to_neg, to_pos, to_bias;
  route_all_t  node_seen;
  int          errors = 0, compares = 0, cycles = 0;

  // The block and the electrodes it switches.
  stage_input_route_config i_stage_input_route_config (.clk(clk), .rst(rst),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_stage(reg_stage),
    .reg_word_sel(reg_word_sel), .reg_wdata(reg_wdata), .reg_rd_valid(reg_rd_valid),
    .reg_rdata(reg_rdata), .active_stage(active_stage), .sense_to_neg(to_neg),
    .sense_to_pos(to_pos), .sense_to_bias(to_bias),
    .minus_frontend_offset_off(minus_off), .plus_frontend_offset_off(plus_off));
  sense_electrodes i_sense_electrodes (.to_neg(to_neg), .to_pos(to_pos),
    .to_bias(to_bias), .node_seen(node_seen));

  // Clock at 25 MHz; the whole run needs some 43 cycles, so 2000 means a hang.
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Register write: strobe held for exactly one edge.
  task automatic wr(input stage_idx_t s, input logic sel, input route_word_t d);
    @(posedge clk);
    #1 {reg_wr_en, reg_stage, reg_word_sel, reg_wdata} = {1'b1, s, sel, d};
    @(posedge clk);
    #1 reg_wr_en = 0;
  endtask

  // Register read: answer stands in the cycle after the strobe.
  task automatic rd(input stage_idx_t s, input logic sel, input route_word_t exp);
    @(posedge clk);
    #1 {reg_rd_en, reg_stage, reg_word_sel} = {1'b1, s, sel};
    @(posedge clk);
    #1 reg_rd_en = 0;
    check(reg_rd_valid, 1'b1);
    check(reg_rdata, exp);
  endtask

  // Select a converting stage and judge what the electrodes and offsets see.
  task automatic see(input stage_idx_t s, input route_word_t lo, input route_word_t hi);
    @(posedge clk);
    #1 active_stage = s;
    @(posedge clk);
    #1 check(node_seen, {hi[13:0], lo[13:0]});
    check({plus_off, minus_off}, hi[15:14]);
  endtask

  // Read-back, including the unused low bits and a stage past the table.
  task automatic t_readback;
    wr(4'h0, 1'b0, 16'hFFFF);
    wr(4'h0, 1'b1, 16'hA5C3);
    wr(4'hC, 1'b0, 16'h1234);
    rd(4'h0, 1'b0, 16'h3FFF);
    rd(4'h0, 1'b1, 16'hA5C3);
    rd(4'hC, 1'b0, 16'h0000);
    $display("test readback done");
  endtask

  // Every route code in both words, two stages swapped, then no stage at all.
  task automatic t_routing;
    wr(4'h3, 1'b0, 16'hF939);
    wr(4'h3, 1'b1, 16'h4E4E);
    wr(4'h7, 1'b0, 16'h0000);
    wr(4'h7, 1'b1, 16'hBFFF);
    see(4'h3, 16'h3939, 16'h4E4E);
    see(4'h7, 16'h0000, 16'hBFFF);
    see(4'h3, 16'h3939, 16'h4E4E);
    see(4'hC, 16'h0000, 16'h0000);
    $display("test routing done");
  endtask

  // A write to the converting stage reaches the switches, then its high word reads back.
  task automatic t_live;
    see(4'h3, 16'h3939, 16'h4E4E);
    wr(4'h3, 1'b0, 16'h0001);
    see(4'h3, 16'h0001, 16'h4E4E);
    rd(4'h3, 1'b1, 16'h4E4E);
    $display("test live write done");
  endtask

  // Reset in mid-run opens every switch and clears the read port.
  task automatic t_reset;
    @(posedge clk);
    #1 rst = 1;
    @(posedge clk);
    #1 check({to_neg, to_pos}, 0);
    check({to_bias, plus_off, minus_off, reg_rd_valid}, 0);
    check(reg_rdata, 0);
    rst = 0;
    $display("test reset done");
  endtask

  // Reset for four cycles, then every switch must be open.
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 0;
    @(posedge clk);
    #1 check(to_neg | to_pos | to_bias, 0);
    t_readback();
    t_routing();
    t_live();
    t_reset();
    final_report();
  end
endmodule
